//--- rtl/rxbc_regs.sv
// Receiver-port register group: parity and self-test error counts, back
// channel configuration and datapath control.
// Assumes all inputs come from logic on clk; the local register port and
// the remote control channel port each give one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "rxbc_regs_map.svh"

module rxbc_regs
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Local register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Remote control channel writes.
  input wire logic rmt_wr,
  input wire logic [7:0] rmt_addr,
  input wire logic [7:0] rmt_wdata,
  // Forward channel datapath load.
  input wire logic fc_load,
  input wire logic [1:0] fc_pin_count,
  input wire logic [7:0] fc_ctl2,
  // Receiver events and self-test count.
  input wire logic parity_err,
  input wire logic lock_acquired,
  input wire logic parity_chk_en_set,
  input wire logic [7:0] bist_err_count,
  // Local I2C transaction steering.
  input wire logic i2c_req,
  input wire logic i2c_addr_match,
  output logic i2c_forward,
  // Configuration outputs.
  output logic pass_all,
  output logic pass_decode,
  output logic auto_ack_all,
  output logic return_link_force_on,
  output logic return_link_enable,
  output logic return_link_checksum_on,
  output logic [2:0] return_link_rate_select,
  output logic block_remote_datapath_load,
  output logic [1:0] forward_pin_count,
  output logic [3:0] forward_pin_enable,
  output logic [7:0] datapath_control_two,
  output logic [7:0] parity_count_high_byte
);

  // ==========================================================
  // State
  rxbc_pkg::rxbc_byte_t bcc_ff; // Back channel configuration.
  rxbc_pkg::rxbc_byte_t nxt_bcc_ff;
  logic block_ff; // Stops forward channel loading.
  logic nxt_block_ff;
  rxbc_pkg::rxbc_pin_code_t pin_ff; // Forward GPIO count code.
  rxbc_pkg::rxbc_pin_code_t nxt_pin_ff;
  rxbc_pkg::rxbc_byte_t ctl2_ff; // Second datapath control byte.
  rxbc_pkg::rxbc_byte_t nxt_ctl2_ff;
  rxbc_pkg::rxbc_byte_t rdata_ff; // Read answer.
  rxbc_pkg::rxbc_byte_t nxt_rdata_ff;
  logic rvalid_ff; // Read answer strobe.
  logic nxt_rvalid_ff;
  logic fwd_ff; // Transaction goes across the link.
  logic nxt_fwd_ff;
  logic link_en_ff; // Return link enable.
  logic nxt_link_en_ff;
  logic [3:0] pin_en_ff; // Enabled forward pins.
  logic [3:0] nxt_pin_en_ff;
  rxbc_pkg::rxbc_count_t par_cnt; // Parity error count.
  logic par_clr; // Clears the parity count.
  logic rd_par_lo; // Read of the low count byte.

  // ==========================================================
  // Parity error counter
  // Lock, checker enable and a low-byte read all restart the count.
  assign rd_par_lo = reg_rd && (reg_addr == `RXBC_ADDR_PAR_LO);
  assign par_clr = rd_par_lo || lock_acquired || parity_chk_en_set;

  rxbc_parity_counter u_par_cnt
  (
    .clk(clk),
    .rst_n(rst_n),
    .err_evt(parity_err),
    .clr_evt(par_clr),
    .count_ff(par_cnt)
  );

  // ==========================================================
  // Configuration registers
  // Order of precedence: remote writes, then forward channel loads, then
  // local writes, so a local write lands in its own cycle, except one to CTL2 while loads are unblocked.
  always_comb
  begin
    nxt_bcc_ff = bcc_ff;
    nxt_block_ff = block_ff;
    nxt_pin_ff = pin_ff;
    nxt_ctl2_ff = ctl2_ff;
    // Remote writes cannot touch the force-on bit.
    if (rmt_wr)
    begin
      unique case (rmt_addr)
        `RXBC_ADDR_BCC:
        begin
          nxt_bcc_ff = (rmt_wdata & ~`RXBC_BCC_LOCAL_ONLY_MASK)
                     | (bcc_ff & `RXBC_BCC_LOCAL_ONLY_MASK);
        end
        `RXBC_ADDR_CTL1:
        begin
          nxt_block_ff = rmt_wdata[`RXBC_CTL1_BLOCK_BIT];
          nxt_pin_ff = rxbc_pkg::rxbc_pin_code_t'(2'(rmt_wdata & `RXBC_CTL1_PIN_MASK));
        end
        `RXBC_ADDR_CTL2:
        begin
          // The reserved byte is only writable while loads are blocked.
          if (block_ff)
          begin
            nxt_ctl2_ff = rmt_wdata;
          end
        end
        default: ; // Other offsets belong elsewhere.
      endcase
    end
    // Forward channel loads are dropped while the block bit is set.
    if (fc_load && !block_ff)
    begin
      nxt_pin_ff = rxbc_pkg::rxbc_pin_code_t'(fc_pin_count);
      nxt_ctl2_ff = fc_ctl2;
    end
    // Local writes; the next unblocked load replaces the pin count again.
    if (reg_wr)
    begin
      unique case (reg_addr)
        `RXBC_ADDR_BCC:
        begin
          nxt_bcc_ff = reg_wdata;
        end
        `RXBC_ADDR_CTL1:
        begin
          nxt_block_ff = reg_wdata[`RXBC_CTL1_BLOCK_BIT];
          nxt_pin_ff = rxbc_pkg::rxbc_pin_code_t'(2'(reg_wdata & `RXBC_CTL1_PIN_MASK));
        end
        `RXBC_ADDR_CTL2:
        begin
          if (block_ff)
          begin
            nxt_ctl2_ff = reg_wdata;
          end
        end
        default: ; // Writes to read-only or foreign offsets are ignored.
      endcase
    end
  end

  // Configuration register bank.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcc_ff <= `RXBC_BCC_RESET;
      block_ff <= 1'(`RXBC_CTL1_RESET >> `RXBC_CTL1_BLOCK_BIT);
      pin_ff <= rxbc_pkg::RXBC_PINS_OFF;
      ctl2_ff <= `RXBC_CTL2_RESET;
    end
    else
    begin
      bcc_ff <= nxt_bcc_ff;
      block_ff <= nxt_block_ff;
      pin_ff <= nxt_pin_ff;
      ctl2_ff <= nxt_ctl2_ff;
    end
  end

  // ==========================================================
  // Read path and derived outputs
  // Read data is registered so every output leaves a flip-flop; the
  // count byte is sampled before the clear of the same read lands.
  always_comb
  begin
    nxt_rvalid_ff = reg_rd;
    nxt_rdata_ff = rdata_ff;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `RXBC_ADDR_PAR_LO: nxt_rdata_ff = par_cnt[7:0];
        `RXBC_ADDR_BIST: nxt_rdata_ff = bist_err_count;
        `RXBC_ADDR_BCC: nxt_rdata_ff = bcc_ff;
        `RXBC_ADDR_CTL1: nxt_rdata_ff = {block_ff, `RXBC_CTL1_RESERVED_ZERO, pin_ff};
        `RXBC_ADDR_CTL2: nxt_rdata_ff = ctl2_ff;
        default: nxt_rdata_ff = `RXBC_RD_UNMAPPED;
      endcase
    end
    // A request leaves only when pass-all is set, or pass-decode is set and its address matches.
    nxt_fwd_ff = i2c_req && (bcc_ff[`RXBC_BCC_PASS_ALL_BIT]
               || (bcc_ff[`RXBC_BCC_PASS_DECODE_BIT] && i2c_addr_match));
    nxt_link_en_ff = bcc_ff[`RXBC_BCC_FORCE_ON_BIT]
                   || bcc_ff[`RXBC_BCC_PASS_ALL_BIT]
                   || bcc_ff[`RXBC_BCC_PASS_DECODE_BIT];
    unique case (pin_ff)
      rxbc_pkg::RXBC_PINS_OFF: nxt_pin_en_ff = `RXBC_PINS_NONE;
      rxbc_pkg::RXBC_PINS_1: nxt_pin_en_ff = `RXBC_PINS_ONE;
      rxbc_pkg::RXBC_PINS_2: nxt_pin_en_ff = `RXBC_PINS_TWO;
      rxbc_pkg::RXBC_PINS_4: nxt_pin_en_ff = `RXBC_PINS_FOUR;
    endcase
  end

  // Read and derived output registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= `RXBC_RD_UNMAPPED;
      rvalid_ff <= 1'b0;
      fwd_ff <= 1'b0;
      link_en_ff <= 1'b1;
      pin_en_ff <= `RXBC_PINS_NONE;
    end
    else
    begin
      rdata_ff <= nxt_rdata_ff;
      rvalid_ff <= nxt_rvalid_ff;
      fwd_ff <= nxt_fwd_ff;
      link_en_ff <= nxt_link_en_ff;
      pin_en_ff <= nxt_pin_en_ff;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign i2c_forward = fwd_ff;
  assign pass_all = bcc_ff[`RXBC_BCC_PASS_ALL_BIT];
  assign pass_decode = bcc_ff[`RXBC_BCC_PASS_DECODE_BIT];
  assign auto_ack_all = bcc_ff[`RXBC_BCC_AUTO_ACK_BIT];
  assign return_link_force_on = bcc_ff[`RXBC_BCC_FORCE_ON_BIT];
  assign return_link_enable = link_en_ff;
  assign return_link_checksum_on = bcc_ff[`RXBC_BCC_CHECKSUM_BIT];
  assign return_link_rate_select = 3'(bcc_ff & `RXBC_BCC_RATE_MASK);
  assign block_remote_datapath_load = block_ff;
  assign forward_pin_count = pin_ff;
  assign forward_pin_enable = pin_en_ff;
  assign datapath_control_two = ctl2_ff;
  assign parity_count_high_byte = par_cnt[15:8];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_par_read;
    rd_par_lo |=> reg_rvalid && (reg_rdata == $past(par_cnt[7:0]));
  endproperty
  a_par_read: assert property (p_par_read)
    else $error("low count byte read wrong value");
  property p_par_clear;
    rd_par_lo && !parity_err |=> (par_cnt == `RXBC_CNT_ZERO);
  endproperty
  a_par_clear: assert property (p_par_clear)
    else $error("count not cleared by low byte read");
  property p_chk_clear;
    parity_chk_en_set && !parity_err |=> (par_cnt == `RXBC_CNT_ZERO);
  endproperty
  a_chk_clear: assert property (p_chk_clear)
    else $error("count not cleared by checker enable");

  property p_bist_read;
    reg_rd && (reg_addr == `RXBC_ADDR_BIST) |=> (reg_rdata == $past(bist_err_count));
  endproperty
  a_bist_read: assert property (p_bist_read)
    else $error("self-test count read wrong value");

  property p_forward;
    i2c_req |=> (i2c_forward == ($past(pass_all) || ($past(pass_decode)
                 && $past(i2c_addr_match))));
  endproperty
  a_forward: assert property (p_forward)
    else $error("forward decision wrong");

  property p_link_en;
    ##1 (return_link_enable == ($past(return_link_force_on) || $past(pass_all)
         || $past(pass_decode)));
  endproperty
  a_link_en: assert property (p_link_en)
    else $error("return link enable wrong");

  property p_remote_keeps_force;
    rmt_wr && !reg_wr && (rmt_addr == `RXBC_ADDR_BCC)
      |=> $stable(return_link_force_on);
  endproperty
  a_remote_keeps_force: assert property (p_remote_keeps_force)
    else $error("remote write changed force-on bit");

  property p_block_load;
    fc_load && block_remote_datapath_load && !reg_wr && !rmt_wr
      |=> $stable(forward_pin_count) && $stable(datapath_control_two);
  endproperty
  a_block_load: assert property (p_block_load)
    else $error("forward load passed the block bit");

  property p_load_pins;
    fc_load && !block_remote_datapath_load && !reg_wr
      |=> (forward_pin_count == $past(fc_pin_count));
  endproperty
  a_load_pins: assert property (p_load_pins)
    else $error("forward load of pin count missed");

  property p_pin_mask;
    (forward_pin_count == 2'h3) [*2] |-> (forward_pin_enable == `RXBC_PINS_FOUR);
  endproperty
  a_pin_mask: assert property (p_pin_mask)
    else $error("four-pin code gives wrong enables");

  c_read_clear: cover property (rd_par_lo && parity_err);
  c_forward: cover property (i2c_req && pass_decode && i2c_addr_match);
  c_blocked: cover property (fc_load && block_remote_datapath_load);
  c_remote_bcc: cover property (rmt_wr && (rmt_addr == `RXBC_ADDR_BCC));

endmodule
`default_nettype wire

//--- rtl/rxbc_regs_map.svh
// Address map, field positions and reset values of the receiver-port
// back channel and datapath register group.
// Included by the register bank and its counter; definitions only.
`ifndef RXBC_REGS_MAP_SVH
`define RXBC_REGS_MAP_SVH

// ==========================================================
// Register offsets on the local register port
`define RXBC_ADDR_PAR_LO 8'h56
`define RXBC_ADDR_BIST 8'h57
`define RXBC_ADDR_BCC 8'h58
`define RXBC_ADDR_CTL1 8'h59
`define RXBC_ADDR_CTL2 8'h5A

// ==========================================================
// Back channel configuration fields
`define RXBC_BCC_PASS_ALL_BIT 7
`define RXBC_BCC_PASS_DECODE_BIT 6
`define RXBC_BCC_AUTO_ACK_BIT 5
`define RXBC_BCC_FORCE_ON_BIT 4
`define RXBC_BCC_CHECKSUM_BIT 3
`define RXBC_BCC_RATE_MASK 8'h07
`define RXBC_BCC_LOCAL_ONLY_MASK 8'h10
`define RXBC_BCC_RESET 8'h18

// ==========================================================
// Datapath control fields
`define RXBC_CTL1_BLOCK_BIT 7
`define RXBC_CTL1_PIN_MASK 8'h03
`define RXBC_CTL1_RESERVED_ZERO 5'h00
`define RXBC_CTL1_RESET 8'h00
`define RXBC_CTL2_RESET 8'h00

// ==========================================================
// Counter and read values
`define RXBC_CNT_ZERO 16'h0000
`define RXBC_CNT_ONE 16'h0001
`define RXBC_CNT_MAX 16'hFFFF
`define RXBC_RD_UNMAPPED 8'h00

// Forward GPIO enable masks per count code
`define RXBC_PINS_NONE 4'h0
`define RXBC_PINS_ONE 4'h1
`define RXBC_PINS_TWO 4'h3
`define RXBC_PINS_FOUR 4'hF

`endif

//--- rtl/rxbc_pkg.sv
// Types shared by the receiver-port back channel register group.
// Assumes the map header supplies all numeric constants.
package rxbc_pkg;

  // One register byte.
  typedef logic [7:0] rxbc_byte_t;

  // Parity error count, low and high byte together.
  typedef logic [15:0] rxbc_count_t;

  // Forward GPIO count field codes.
  typedef enum logic [1:0] {
    RXBC_PINS_OFF,
    RXBC_PINS_1,
    RXBC_PINS_2,
    RXBC_PINS_4
  } rxbc_pin_code_t;

endpackage

//--- rtl/rxbc_parity_counter.sv
// Saturating parity error counter with a clear that loses to a new error.
// Assumes error and clear strobes are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
`include "rxbc_regs_map.svh"

module rxbc_parity_counter
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Events.
  input wire logic err_evt,
  input wire logic clr_evt,
  // Count.
  output var rxbc_pkg::rxbc_count_t count_ff
);

  // Next count value.
  rxbc_pkg::rxbc_count_t nxt_count_ff;

  // ==========================================================
  // Counting
  // A clear in the same cycle as an error leaves a count of one, so the
  // error is never lost.
  always_comb
  begin
    nxt_count_ff = count_ff;
    if (clr_evt)
    begin
      // The error of this cycle survives the clear.
      nxt_count_ff = err_evt ? `RXBC_CNT_ONE : `RXBC_CNT_ZERO;
    end
    else if (err_evt && (count_ff != `RXBC_CNT_MAX))
    begin
      // Holding at the top keeps a heavy error burst from reading as few.
      nxt_count_ff = count_ff + `RXBC_CNT_ONE;
    end
  end

  // Count register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff <= `RXBC_CNT_ZERO;
    end
    else
    begin
      count_ff <= nxt_count_ff;
    end
  end

  // ==========================================================
  // Checks
  property p_cnt_saturate;
    @(posedge clk) disable iff (!rst_n)
    (count_ff == `RXBC_CNT_MAX) && !clr_evt |=> (count_ff == `RXBC_CNT_MAX);
  endproperty
  a_cnt_saturate: assert property (p_cnt_saturate)
    else $error("parity counter left its ceiling");

  property p_cnt_step;
    @(posedge clk) disable iff (!rst_n)
    err_evt && !clr_evt && (count_ff != `RXBC_CNT_MAX)
      |=> (count_ff == $past(count_ff) + `RXBC_CNT_ONE);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("parity counter missed an error");

  c_cnt_full: cover property (@(posedge clk) count_ff == `RXBC_CNT_MAX);

endmodule
`default_nettype wire

//--- bench/rxbc_serializer_model.sv
// Stand-in for the remote serializer: remote control writes and
// forward channel datapath loads. Tasks are called just after an edge.
`timescale 1ns/1ps
`default_nettype none

module rxbc_serializer_model
(
  // Clock.
  input wire logic clk,
  // Remote control channel.
  output logic rmt_wr,
  output logic [7:0] rmt_addr,
  output logic [7:0] rmt_wdata,
  // Forward channel datapath load.
  output logic fc_load,
  output logic [1:0] fc_pin_count,
  output logic [7:0] fc_ctl2
);
  // ==========================================================
  // Idle state
  initial
  begin
    rmt_wr = 1'b0;
    rmt_addr = 8'h00;
    rmt_wdata = 8'h00;
    fc_load = 1'b0;
    fc_pin_count = 2'h0;
    fc_ctl2 = 8'h00;
  end

  // One remote write; released lines show the inverse so stale data is never trusted.
  task automatic remote_write(input logic [7:0] a, input logic [7:0] d);
    rmt_addr = a;
    rmt_wdata = d;
    rmt_wr = 1'b1;
    @(posedge clk);
    #1;
    rmt_wr = 1'b0;
    rmt_addr = ~a;
    rmt_wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  // The serializer normally supplies the datapath fields.
  task automatic forward_load(input logic [1:0] c, input logic [7:0] d);
    fc_pin_count = c;
    fc_ctl2 = d;
    fc_load = 1'b1;
    @(posedge clk);
    #1;
    fc_load = 1'b0;
    fc_pin_count = ~c;
    fc_ctl2 = ~d;
    @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

//--- bench/rxbc_regs_tb_top.sv
// Self-checking bench for the receiver-port register group.
// Assumes the serializer model drives the remote and forward-load ports.
`timescale 1ns/1ps
`default_nettype none

module rxbc_regs_tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rxbc_row_t;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, rmt_wr, fc_load, parity_err;
  logic lock_acquired, parity_chk_en_set, i2c_req, i2c_addr_match, i2c_forward;
  logic pass_all, pass_decode, auto_ack_all, force_on, rl_en, cks_on, block;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rmt_addr, rmt_wdata, fc_ctl2, bist, ctl2, hi;
  logic [7:0] rd;
  logic [2:0] rate;
  logic [1:0] fc_pin_count, pin_cnt;
  logic [3:0] pin_en;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // Write then read-back rows; writes to read-only or unmapped places must not land.
  rxbc_row_t rows[10] = '{'{8'h58, 8'hFF, 8'hFF}, '{8'h58, 8'h01, 8'h01},
    '{8'h59, 8'h7E, 8'h02}, '{8'h5A, 8'h33, 8'h00}, '{8'h59, 8'hFF, 8'h83},
    '{8'h5A, 8'h33, 8'h33}, '{8'h57, 8'h12, 8'hA5}, '{8'h56, 8'h12, 8'h00},
    '{8'h60, 8'h44, 8'h00}, '{8'h59, 8'h00, 8'h00}};
  logic [3:0] pin_map[4] = '{4'h0, 4'h1, 4'h3, 4'hF};

  rxbc_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rmt_wr(rmt_wr), .rmt_addr(rmt_addr), .rmt_wdata(rmt_wdata),
    .fc_load(fc_load), .fc_pin_count(fc_pin_count), .fc_ctl2(fc_ctl2),
    .parity_err(parity_err), .lock_acquired(lock_acquired),
    .parity_chk_en_set(parity_chk_en_set), .bist_err_count(bist), .i2c_req(i2c_req),
    .i2c_addr_match(i2c_addr_match), .i2c_forward(i2c_forward), .pass_all(pass_all),
    .pass_decode(pass_decode), .auto_ack_all(auto_ack_all), .return_link_force_on(force_on),
    .return_link_enable(rl_en), .return_link_checksum_on(cks_on),
    .return_link_rate_select(rate), .block_remote_datapath_load(block),
    .forward_pin_count(pin_cnt), .forward_pin_enable(pin_en),
    .datapath_control_two(ctl2), .parity_count_high_byte(hi));

  rxbc_serializer_model ser_u (.clk(clk), .rmt_wr(rmt_wr), .rmt_addr(rmt_addr),
    .rmt_wdata(rmt_wdata), .fc_load(fc_load), .fc_pin_count(fc_pin_count),
    .fc_ctl2(fc_ctl2));

  // ==========================================================
  // Clock, and a cycle ceiling well above the saturation run.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  // The answer stands one cycle, so it is taken right after the edge.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    check(reg_rvalid, 1'b1, "read answer");
    d = reg_rdata;
    reg_rd = 1'b0;
    tick();
  endtask
  task automatic pulse_err(input int n);
    parity_err = 1'b1;
    repeat (n) tick();
    parity_err = 1'b0;
    tick();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, reg_wr, reg_rd, parity_err, lock_acquired, parity_chk_en_set} = 6'h00;
    {i2c_req, i2c_addr_match, reg_addr, reg_wdata} = 18'h00000;
    bist = 8'hA5;
    repeat (2) tick();
    rst_n = 1'b1;
    reg_read(8'h58, rd);
    check(rd, 8'h18, "config reset");
    check(rl_en, 1'b1, "link enable at reset");
    reg_read(8'h59, rd);
    check(rd, 8'h00, "ctl1 reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      reg_write(rows[i].a, rows[i].d);
      reg_read(rows[i].a, rd);
      check(rd, rows[i].e, "row read-back");
      if (rows[i].a == 8'h58)
        check({pass_all, pass_decode, auto_ack_all, force_on, cks_on, rate}, rows[i].e,
          "config outputs");
    end
    $display("test table done");
    // Steering over every pass-through and address-match case.
    for (int i = 0; i < 8; i++)
    begin
      reg_write(8'h58, {i[2], i[1], 6'h00});
      check(rl_en, i[2] | i[1], "link enable");
      i2c_addr_match = i[0];
      i2c_req = 1'b1;
      tick();
      i2c_req = 1'b0;
      check(i2c_forward, i[2] | (i[1] & i[0]), "forwarding");
      tick();
    end
    $display("test steering done");
    reg_write(8'h58, 8'h18);
    ser_u.remote_write(8'h58, 8'h00);
    reg_read(8'h58, rd);
    check(rd, 8'h10, "force-on kept from remote");
    reg_write(8'h58, 8'h00);
    ser_u.remote_write(8'h58, 8'h20);
    ser_u.remote_write(8'h58, 8'h31);
    reg_read(8'h58, rd);
    check(rd, 8'h21, "remote rate change");
    $display("test remote done");
    for (int c = 0; c < 4; c++)
    begin
      ser_u.forward_load(c[1:0], 8'h50 + 8'(c));
      check(pin_cnt, c[1:0], "loaded pin count");
      check(pin_en, pin_map[c], "pin enables");
      check(ctl2, 8'h50 + 8'(c), "loaded ctl2");
    end
    reg_write(8'h59, 8'h81);
    check(block, 1'b1, "block bit set");
    ser_u.forward_load(2'h3, 8'h99);
    check(pin_cnt, 2'h1, "blocked load count");
    reg_read(8'h5A, rd);
    check(rd, 8'h53, "blocked load ctl2");
    ser_u.remote_write(8'h59, 8'h82);
    check(pin_cnt, 2'h2, "remote pin count");
    check(block, 1'b1, "remote keeps block bit");
    ser_u.remote_write(8'h5A, 8'h77);
    check(ctl2, 8'h77, "remote ctl2 while blocked");
    $display("test datapath done");
    pulse_err(3);
    reg_read(8'h56, rd);
    check(rd, 8'h03, "count");
    reg_read(8'h56, rd);
    check(rd, 8'h00, "cleared by read");
    pulse_err(2);
    parity_chk_en_set = 1'b1;
    tick();
    parity_chk_en_set = 1'b0;
    reg_read(8'h56, rd);
    check(rd, 8'h00, "cleared by enable");
    pulse_err(2);
    {lock_acquired, parity_chk_en_set, parity_err} = 3'h7;
    tick();
    {lock_acquired, parity_chk_en_set, parity_err} = 3'h0;
    reg_read(8'h56, rd);
    check(rd, 8'h01, "error beats clear");
    pulse_err(65540);
    check(hi, 8'hFF, "saturated high");
    reg_read(8'h56, rd);
    check(rd, 8'hFF, "saturated low");
    check(hi, 8'h00, "high cleared by low read");
    $display("test parity done");
    conclude();
  end
endmodule

`default_nettype wire
